// File: dv/tb_flash_self_program_sequencer.sv
`timescale 1ns/1ps
`include "fsps_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module tb_flash_self_program_sequencer;
  localparam int CYC = 20;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic por_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, cpu_force_nop_out, cpu_stall_out;
  logic flash_erase_start_out, flash_prog_start_out, flash_busy_out;
  logic [10:0] flash_row_out, cap_row;
  logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] flash_latch_data_out, cap_lat;
  logic [13:0] exp_l [16];
  logic [31:0] rd;
  logic se;
  int err_count = 0;
  int comparisons = 0;
  int prog_cnt = 0, erase_cnt = 0, nop_cnt = 0, stall_cnt = 0, diff_cnt = 0;
  int p0, e0, n0, s0;

  fsps_sequencer #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cpu_force_nop_out(cpu_force_nop_out), .cpu_stall_out(cpu_stall_out),
    .flash_erase_start_out(flash_erase_start_out),
    .flash_prog_start_out(flash_prog_start_out), .flash_busy_out(flash_busy_out),
    .flash_row_out(flash_row_out), .flash_latch_data_out(flash_latch_data_out)
  );

  // ****************************************************************
  // Clock, monitors and helpers.
  // ****************************************************************
  // The clock toggles every half period of 2.5 ns.
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // Counts pulses and stall cycles, and grabs the row image at each start pulse.
  always @(posedge clk_sys_in) begin
    if (flash_prog_start_out === 1'b1) prog_cnt++;
    if (flash_erase_start_out === 1'b1) erase_cnt++;
    if (flash_prog_start_out === 1'b1 || flash_erase_start_out === 1'b1) begin
      cap_lat = flash_latch_data_out;
      cap_row = flash_row_out;
    end
    if (cpu_force_nop_out === 1'b1) nop_cnt++;
    if (cpu_stall_out === 1'b1) stall_cnt++;
    if (cpu_stall_out !== flash_busy_out) diff_cnt++;
  end

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    se = pslverr_out;
    `CHK("wait cycles", 2, n)
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  // Unlock keys, go write, then poll until the go bit drops.
  task automatic go(input logic [7:0] ctl);
    int n;
    n = 0;
    p0 = prog_cnt; e0 = erase_cnt; n0 = nop_cnt; s0 = stall_cnt;
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'h55);
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'hAA);
    apb(1'b1, `FSPS_OFS_CONTROL, {24'h0, ctl});
    do begin
      apb(1'b0, `FSPS_OFS_CONTROL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 100);
  endtask

  task automatic cnts(input int dp, input int de, input int dn, input int ds);
    `CHK("prog pulses", dp, prog_cnt - p0)
    `CHK("erase pulses", de, erase_cnt - e0)
    `CHK("nop cycles", dn, nop_cnt - n0)
    `CHK("stall cycles", ds, stall_cnt - s0)
  endtask

  function automatic logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] flat();
    logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] r;
    for (int i = 0; i < 16; i++) r[i*14 +: 14] = exp_l[i];
    return r;
  endfunction

  task automatic blank();
    foreach (exp_l[i]) exp_l[i] = `FSPS_BLANK_WORD;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("read data", ex, rd)
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rd_chk(`FSPS_OFS_CONTROL, 32'h80);
    rd_chk(`FSPS_OFS_ADDR_HIGH, 32'h80);
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'h55);
    rd_chk(`FSPS_OFS_UNLOCK, 32'h0);
    rd_chk(8'h18, 32'h0);
    `CHK("slverr", 1'b1, se)
    `CHK("latches", flat(), flash_latch_data_out)
  endtask

  task automatic t_load();
    apb(1'b1, `FSPS_OFS_ADDR_LOW, 32'h37);
    apb(1'b1, `FSPS_OFS_ADDR_HIGH, 32'h5A);
    apb(1'b1, `FSPS_OFS_WORD_LOW, 32'hC3);
    apb(1'b1, `FSPS_OFS_WORD_HIGH, 32'h2B);
    go(8'h26);
    exp_l[7] = 14'h2BC3;
    `CHK("latches", flat(), flash_latch_data_out)
    cnts(0, 0, 2, 0);
    apb(1'b1, `FSPS_OFS_WORD_LOW, 32'h00);
    `CHK("latches", flat(), flash_latch_data_out)
    rd_chk(`FSPS_OFS_CONTROL, 32'hA4);
  endtask

  task automatic t_refuse();
    p0 = prog_cnt; e0 = erase_cnt; n0 = nop_cnt; s0 = stall_cnt;
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'h55);
    apb(1'b0, `FSPS_OFS_UNLOCK, 32'h0);
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'hAA);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h26);
    rd_chk(`FSPS_OFS_CONTROL, 32'hAC);
    `CHK("latches", flat(), flash_latch_data_out)
    cnts(0, 0, 0, 0);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h24);
    go(8'h22);
    rd_chk(`FSPS_OFS_CONTROL, 32'hA8);
    `CHK("latches", flat(), flash_latch_data_out)
    cnts(0, 0, 0, 0);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h24);
  endtask

  task automatic t_prog();
    apb(1'b1, `FSPS_OFS_ADDR_LOW, 32'h30);
    apb(1'b1, `FSPS_OFS_WORD_LOW, 32'h11);
    apb(1'b1, `FSPS_OFS_WORD_HIGH, 32'h05);
    go(8'h06);
    exp_l[0] = 14'h0511;
    `CHK("programmed image", flat(), cap_lat)
    `CHK("programmed row", 11'h5A3, cap_row)
    cnts(1, 0, 2, CYC);
    blank();
    `CHK("latches", flat(), flash_latch_data_out)
    rd_chk(`FSPS_OFS_CONTROL, 32'h84);
  endtask

  task automatic t_erase();
    apb(1'b1, `FSPS_OFS_ADDR_LOW, 32'h3F);
    go(8'h26);
    exp_l[15] = 14'h0511;
    `CHK("latches", flat(), flash_latch_data_out)
    apb(1'b1, `FSPS_OFS_ADDR_LOW, 32'h39);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h14);
    go(8'h16);
    `CHK("erased row", 11'h5A3, cap_row)
    cnts(0, 1, 2, CYC);
    blank();
    `CHK("latches", flat(), flash_latch_data_out)
    rd_chk(`FSPS_OFS_CONTROL, 32'h84);
    apb(1'b1, `FSPS_OFS_WORD_HIGH, 32'h3A);
    go(8'h06);
    exp_l[9] = 14'h3A11;
    `CHK("rewritten image", flat(), cap_lat)
    `CHK("rewritten row", 11'h5A3, cap_row)
    blank();
    `CHK("stall vs busy", 0, diff_cnt)
  endtask

  task automatic t_fault();
    int n;
    n = 0;
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'h55);
    apb(1'b1, `FSPS_OFS_UNLOCK, 32'hAA);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h06);
    while (cpu_stall_out !== 1'b1 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rd_chk(`FSPS_OFS_CONTROL, 32'h88);
    apb(1'b1, `FSPS_OFS_CONTROL, 32'h00);
    rd_chk(`FSPS_OFS_CONTROL, 32'h80);
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict.
  // ****************************************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence: reset for 12 cycles, then every scenario in turn.
  initial begin
    blank();
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset();
    t_load();
    t_refuse();
    t_prog();
    t_erase();
    t_fault();
    summarize();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    err_count++;
    $display("MISMATCH watchdog exp done got hang");
    summarize();
  end
endmodule

// File: rtl/fsps_defines.svh
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the APB.
// ****************************************************************
`define FSPS_OFS_ADDR_LOW 8'h00
`define FSPS_OFS_ADDR_HIGH 8'h04
`define FSPS_OFS_WORD_LOW 8'h08
`define FSPS_OFS_WORD_HIGH 8'h0C
`define FSPS_OFS_CONTROL 8'h10
`define FSPS_OFS_UNLOCK 8'h14

// ****************************************************************
// Control register field positions.
// ****************************************************************
`define FSPS_BIT_CFG_SEL 6
`define FSPS_BIT_LATCH_ONLY 5
`define FSPS_BIT_ERASE_SEL 4
`define FSPS_BIT_FAULT 3
`define FSPS_BIT_PROG_EN 2
`define FSPS_BIT_WRITE_GO 1

// ****************************************************************
// Widths, reset values and keys.
// ****************************************************************
`define FSPS_LATCHES 16
`define FSPS_WORD_W 14
`define FSPS_ROW_W 11
`define FSPS_BLANK_WORD 14'h3FFF
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'hAA

// ****************************************************************
// Timing.
// ****************************************************************
`define FSPS_CLK_MHZ 200
`define FSPS_ERASE_TIME_NS 2000000
`define FSPS_PROG_TIME_NS 2000000

`endif

// File: rtl/fsps_latch_bank.sv
`timescale 1ns/1ps
`include "fsps_defines.svh"

// Bank of write latches holding one row image, all blank after reset or clear.
module fsps_latch_bank (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_idx_in,
  input wire logic [`FSPS_WORD_W-1:0] wr_data_in,
  input wire logic clear_in,
  output logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] latch_flat_out
);

  logic [`FSPS_WORD_W-1:0] latch_r [`FSPS_LATCHES];

  // Clear wins over load; a load lands in the latch chosen by the low address bits.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `FSPS_LATCHES; i++) begin
        latch_r[i] <= `FSPS_BLANK_WORD;
      end
    end else if (clear_in) begin
      for (int i = 0; i < `FSPS_LATCHES; i++) begin
        latch_r[i] <= `FSPS_BLANK_WORD;
      end
    end else if (wr_en_in) begin
      latch_r[wr_idx_in] <= wr_data_in;
    end
  end

  // Flatten the bank, latch 0 in the low bits.
  genvar g;
  generate
    for (g = 0; g < `FSPS_LATCHES; g++) begin : g_flat
      assign latch_flat_out[g*`FSPS_WORD_W +: `FSPS_WORD_W] = latch_r[g];
    end
  endgenerate

endmodule

// File: rtl/fsps_pkg.sv
package fsps_pkg;

  // Sequencer states, Gray coded along idle, setup, setup, busy, done.
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'h0,
    FSPS_NOP1 = 3'h1,
    FSPS_NOP2 = 3'h3,
    FSPS_BUSY = 3'h2,
    FSPS_DONE = 3'h6
  } fsps_state_t;

  // Progress through the two-byte unlock key.
  typedef enum logic [1:0] {
    FSPS_KEY_NONE = 2'h0,
    FSPS_KEY_HALF = 2'h1,
    FSPS_KEY_OPEN = 2'h3
  } fsps_key_t;

  // Kind of operation launched by the go bit.
  typedef enum logic [1:0] {
    FSPS_OP_LOAD = 2'h0,
    FSPS_OP_PROG = 2'h1,
    FSPS_OP_ERASE = 2'h2
  } fsps_op_t;

endpackage

// File: rtl/fsps_sequencer.sv
// What this block does
// - Erase works on whole rows only; any address in the row picks it.
// - Two setup cycles with forced no-ops follow the go write.
// - Row erase stalls the processor about 2 ms while clocks keep running.
// - After erase, execution resumes at the third instruction after go.
// - Programming never erases; software must pre-erase target words.
// - One program writes one or more words, at most one per latch.
// - Upper 11 address bits pick the row; lower 4 pick the latch.
// - Programming never crosses a row; all latches go to that row.
// - Every program or erase completion sets all latches to 0x3FFF.
// - Latch-only set: go loads the addressed latch and writes no flash.
// - Latch-only clear: go loads the latch, then programs all latches.
// - An interrupted key sequence loads no latch and starts no write.
// - Each latch word is taken from the data registers at go.
// - Row program stalls after the two no-ops until the write ends.
// - Software only sets the go bit; hardware clears it on completion.
// - Program enable is clear after reset; nothing runs without it.
// - A reset during program or erase sets the fault flag.
// - The unlock key port is write-only and reads as zero.
`timescale 1ns/1ps
`include "fsps_defines.svh"

module fsps_sequencer #(
  parameter int ERASE_CYCLES = `FSPS_ERASE_TIME_NS * `FSPS_CLK_MHZ / 1000,
  parameter int PROG_CYCLES = `FSPS_PROG_TIME_NS * `FSPS_CLK_MHZ / 1000
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic cpu_force_nop_out,
  output logic cpu_stall_out,
  output logic flash_erase_start_out,
  output logic flash_prog_start_out,
  output logic flash_busy_out,
  output logic [`FSPS_ROW_W-1:0] flash_row_out,
  output logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] flash_latch_data_out
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [14:0] addr_r;
  logic [`FSPS_WORD_W-1:0] word_r;
  logic cfg_sel_r, latch_only_r, erase_sel_r, prog_en_r, write_go_r, fault_r, op_active_r;
  logic [19:0] timer_r;
  logic acc, wr_acc, go_req, start, done, latch_load;
  fsps_pkg::fsps_key_t key_r;
  fsps_pkg::fsps_op_t op_r, op_nxt;
  fsps_pkg::fsps_state_t state_r, state_nxt;
  logic [31:0] rdata_nxt;
  logic unmapped;

  // ****************************************************************
  // APB slave: one wait cycle, then a registered answer.
  // ****************************************************************

  // The transfer completes on the edge where pready is already high.
  assign acc = psel_in && penable_in && pready_out;
  assign wr_acc = acc && pwrite_in;

  // Read data mux and decode of unmapped offsets.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unmapped = 1'b0;
    case (paddr_in)
      `FSPS_OFS_ADDR_LOW: rdata_nxt = {24'h00_0000, addr_r[7:0]};
      `FSPS_OFS_ADDR_HIGH: rdata_nxt = {24'h00_0000, 1'b1, addr_r[14:8]};
      `FSPS_OFS_WORD_LOW: rdata_nxt = {24'h00_0000, word_r[7:0]};
      `FSPS_OFS_WORD_HIGH: rdata_nxt = {26'h000_0000, word_r[13:8]};
      `FSPS_OFS_CONTROL: rdata_nxt = {24'h00_0000, 1'b1, cfg_sel_r, latch_only_r, erase_sel_r,
                                      fault_r, prog_en_r, write_go_r, 1'b0};
      `FSPS_OFS_UNLOCK: rdata_nxt = 32'h0000_0000;
      default: unmapped = 1'b1;
    endcase
  end

  // Ready rises one cycle into the access phase and falls after the transfer.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out <= 1'b1;
      prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_nxt;
      pslverr_out <= unmapped;
    end else begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  property p_key_reads_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      psel_in && penable_in && !pwrite_in && !pready_out && paddr_in == `FSPS_OFS_UNLOCK |=>
        pready_out && prdata_out == 32'h0000_0000;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("unlock port read");

  // ****************************************************************
  // Address and data registers.
  // ****************************************************************

  // Plain software writes; the data pair feeds the latch at go.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= 15'h0000;
      word_r <= 14'h0000;
    end else if (wr_acc) begin
      case (paddr_in)
        `FSPS_OFS_ADDR_LOW: addr_r[7:0] <= pwdata_in[7:0];
        `FSPS_OFS_ADDR_HIGH: addr_r[14:8] <= pwdata_in[6:0];
        `FSPS_OFS_WORD_LOW: word_r[7:0] <= pwdata_in[7:0];
        `FSPS_OFS_WORD_HIGH: word_r[13:8] <= pwdata_in[5:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Unlock key recognition.
  // ****************************************************************

  // 55h then AAh on back-to-back accesses opens the lock for the next access only.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_r <= fsps_pkg::FSPS_KEY_NONE;
    end else if (acc) begin
      if (pwrite_in && paddr_in == `FSPS_OFS_UNLOCK &&
          pwdata_in[7:0] == `FSPS_KEY_FIRST) begin
        key_r <= fsps_pkg::FSPS_KEY_HALF;
      end else if (pwrite_in && paddr_in == `FSPS_OFS_UNLOCK &&
                   pwdata_in[7:0] == `FSPS_KEY_SECOND && key_r == fsps_pkg::FSPS_KEY_HALF) begin
        key_r <= fsps_pkg::FSPS_KEY_OPEN;
      end else begin
        key_r <= fsps_pkg::FSPS_KEY_NONE;
      end
    end
  end

  // ****************************************************************
  // Go decode and launch.
  // ****************************************************************

  // Go starts only when unlocked, enabled, idle and aimed at program flash.
  assign go_req = wr_acc && paddr_in == `FSPS_OFS_CONTROL && pwdata_in[`FSPS_BIT_WRITE_GO];
  assign start = go_req && key_r == fsps_pkg::FSPS_KEY_OPEN &&
                 pwdata_in[`FSPS_BIT_PROG_EN] && !pwdata_in[`FSPS_BIT_CFG_SEL] &&
                 state_r == fsps_pkg::FSPS_IDLE;
  assign done = state_r == fsps_pkg::FSPS_DONE;

  // Operation kind follows erase select first, then latch-only.
  always_comb begin
    if (pwdata_in[`FSPS_BIT_ERASE_SEL]) begin
      op_nxt = fsps_pkg::FSPS_OP_ERASE;
    end else if (pwdata_in[`FSPS_BIT_LATCH_ONLY]) begin
      op_nxt = fsps_pkg::FSPS_OP_LOAD;
    end else begin
      op_nxt = fsps_pkg::FSPS_OP_PROG;
    end
  end

  // Erase leaves the latches alone; load and program both take the data pair now.
  assign latch_load = start && op_nxt != fsps_pkg::FSPS_OP_ERASE;

  property p_go_needs_key;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      go_req && key_r != fsps_pkg::FSPS_KEY_OPEN && state_r == fsps_pkg::FSPS_IDLE |=>
        state_r == fsps_pkg::FSPS_IDLE && !write_go_r;
  endproperty
  a_go_needs_key: assert property (p_go_needs_key) else $error("go taken without key");

  // ****************************************************************
  // Control register.
  // ****************************************************************

  // Go is set-only; hardware clears go when the operation ends, and erase select when an erase ends.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_sel_r <= 1'b0;
      latch_only_r <= 1'b0;
      erase_sel_r <= 1'b0;
      prog_en_r <= 1'b0;
      write_go_r <= 1'b0;
      op_r <= fsps_pkg::FSPS_OP_LOAD;
    end else begin
      if (wr_acc && paddr_in == `FSPS_OFS_CONTROL) begin
        cfg_sel_r <= pwdata_in[`FSPS_BIT_CFG_SEL];
        latch_only_r <= pwdata_in[`FSPS_BIT_LATCH_ONLY];
        erase_sel_r <= pwdata_in[`FSPS_BIT_ERASE_SEL];
        prog_en_r <= pwdata_in[`FSPS_BIT_PROG_EN];
      end else if (done && op_r == fsps_pkg::FSPS_OP_ERASE) begin
        erase_sel_r <= 1'b0;
      end
      if (start) begin
        write_go_r <= 1'b1;
        op_r <= op_nxt;
      end else if (done) begin
        write_go_r <= 1'b0;
      end
    end
  end

  property p_go_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(write_go_r) |-> $past(state_r) == fsps_pkg::FSPS_DONE;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go cleared early");
  property p_erase_clears_sel;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      done && op_r == fsps_pkg::FSPS_OP_ERASE |=> !erase_sel_r && !write_go_r;
  endproperty
  a_erase_clears_sel: assert property (p_erase_clears_sel) else $error("erase bit kept");
  property p_enable_gate;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (flash_erase_start_out || flash_prog_start_out) |-> $past(prog_en_r, 2);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("write without enable");

  // ****************************************************************
  // Fault flag, kept across device resets.
  // ****************************************************************

  // An operation still marked active while the sequencer sits idle was cut by reset.
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) begin
      op_active_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      if (state_r == fsps_pkg::FSPS_BUSY) begin
        op_active_r <= 1'b1;
      end else if (state_r == fsps_pkg::FSPS_IDLE || done) begin
        op_active_r <= 1'b0;
      end
      if ((op_active_r && state_r == fsps_pkg::FSPS_IDLE) || (go_req && !start)) begin
        fault_r <= 1'b1;
      end else if (wr_acc && paddr_in == `FSPS_OFS_CONTROL && !pwdata_in[`FSPS_BIT_FAULT]) begin
        fault_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer state machine.
  // ****************************************************************

  // Two forced no-op cycles, then a timed stall for erase or program only.
  always_comb begin
    case (state_r)
      fsps_pkg::FSPS_IDLE: state_nxt = start ? fsps_pkg::FSPS_NOP1 : fsps_pkg::FSPS_IDLE;
      fsps_pkg::FSPS_NOP1: state_nxt = fsps_pkg::FSPS_NOP2;
      fsps_pkg::FSPS_NOP2: state_nxt = (op_r == fsps_pkg::FSPS_OP_LOAD) ?
                                       fsps_pkg::FSPS_DONE : fsps_pkg::FSPS_BUSY;
      fsps_pkg::FSPS_BUSY: state_nxt = (timer_r == 20'h0_0000) ?
                                       fsps_pkg::FSPS_DONE : fsps_pkg::FSPS_BUSY;
      fsps_pkg::FSPS_DONE: state_nxt = fsps_pkg::FSPS_IDLE;
      default: state_nxt = fsps_pkg::FSPS_IDLE;
    endcase
  end

  // State register with the processor-facing outputs registered from the next state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= fsps_pkg::FSPS_IDLE;
      cpu_force_nop_out <= 1'b0;
      cpu_stall_out <= 1'b0;
      flash_busy_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cpu_force_nop_out <= state_nxt == fsps_pkg::FSPS_NOP1 ||
                           state_nxt == fsps_pkg::FSPS_NOP2;
      cpu_stall_out <= state_nxt == fsps_pkg::FSPS_BUSY;
      flash_busy_out <= state_nxt == fsps_pkg::FSPS_BUSY;
    end
  end

  property p_two_nops;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      start |=> cpu_force_nop_out [*2] ##1 !cpu_force_nop_out;
  endproperty
  a_two_nops: assert property (p_two_nops) else $error("no-op window not two cycles");
  property p_load_no_stall;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      start && op_nxt == fsps_pkg::FSPS_OP_LOAD |-> ##1 !cpu_stall_out [*4];
  endproperty
  a_load_no_stall: assert property (p_load_no_stall) else $error("latch load stalled");
  property p_prog_stalls;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      start && op_nxt != fsps_pkg::FSPS_OP_LOAD |-> ##3 cpu_stall_out && !cpu_force_nop_out;
  endproperty
  a_prog_stalls: assert property (p_prog_stalls) else $error("no stall after no-ops");

  // Self-timed write or erase duration, loaded as the stall begins.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_r <= 20'h0_0000;
    end else if (state_r == fsps_pkg::FSPS_NOP2) begin
      timer_r <= (op_r == fsps_pkg::FSPS_OP_ERASE) ? 20'(ERASE_CYCLES - 1) :
                 20'(PROG_CYCLES - 1);
    end else if (state_r == fsps_pkg::FSPS_BUSY && timer_r != 20'h0_0000) begin
      timer_r <= timer_r - 20'h0_0001;
    end
  end

  // ****************************************************************
  // Flash array side.
  // ****************************************************************

  // One start pulse per program or erase, none for a latch-only load; the row comes from the upper address bits only.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_erase_start_out <= 1'b0;
      flash_prog_start_out <= 1'b0;
      flash_row_out <= 11'h000;
    end else begin
      flash_erase_start_out <= state_r == fsps_pkg::FSPS_NOP2 &&
                               op_r == fsps_pkg::FSPS_OP_ERASE;
      flash_prog_start_out <= state_r == fsps_pkg::FSPS_NOP2 &&
                              op_r == fsps_pkg::FSPS_OP_PROG;
      if (start) begin
        flash_row_out <= addr_r[14:4];
      end
    end
  end

  property p_row_steady;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      state_r == fsps_pkg::FSPS_BUSY |-> $stable(flash_row_out);
  endproperty
  a_row_steady: assert property (p_row_steady) else $error("row moved in busy");

  // Latch bank: loads at go, blanked when program or erase completes.
  fsps_latch_bank u_latch_bank (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(latch_load),
    .wr_idx_in(addr_r[3:0]),
    .wr_data_in(word_r),
    .clear_in(done && op_r != fsps_pkg::FSPS_OP_LOAD),
    .latch_flat_out(flash_latch_data_out)
  );

  property p_blank_after;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      done && op_r != fsps_pkg::FSPS_OP_LOAD |=>
        flash_latch_data_out == {`FSPS_LATCHES{`FSPS_BLANK_WORD}};
  endproperty
  a_blank_after: assert property (p_blank_after) else $error("latches not blank");

endmodule
